// File: swg_pkg.sv
// Operation
// - status pin selects end-of-sweep or each step
// - status pin idle unless its enable set
// - top-bit pin is inverse of DAC MSB
// - top-bit pin driven only when enabled
// - interrupt rising edge resets sweep machines
// - after interrupt, DAC code goes midscale
// - trigger rising edge initialises and starts sweep
// - auto mode: one trigger runs whole sweep
// - external mode: each trigger advances one step
// - 16-bit word, address first, data MSB-first
// - serial bits captured on falling serial clock
// - frame select low starts a new word
// - standby high freezes all sequencing logic
// - output frequency is fraction of clock
// - frame held low accepts consecutive words
package swg_pkg;
  // serial word layout
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned ADDR_BITS = 4;
  localparam int unsigned DATA_BITS = 12;
  localparam logic [3:0] LAST_BIT = 4'hf;
  // synthesis datapath
  localparam int unsigned PHASE_W = 24;
  localparam int unsigned DAC_W = 10;
  localparam logic [9:0] DAC_MID = 10'h200;
  // register indices (byte address is four times the index)
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_FSTART_LO = 4'h1;
  localparam logic [3:0] IDX_FSTART_HI = 4'h2;
  localparam logic [3:0] IDX_DELTA_LO = 4'h3;
  localparam logic [3:0] IDX_DELTA_HI = 4'h4;
  localparam logic [3:0] IDX_NINCR = 4'h5;
  localparam logic [3:0] IDX_TINT = 4'h6;
  localparam logic [3:0] IDX_STATUS = 4'h8;
  localparam int unsigned WB_ADR_W = 8;
  // control register bit positions
  localparam int unsigned CTRL_STATUS_SRC = 0;
  localparam int unsigned CTRL_STATUS_EN = 1;
  localparam int unsigned CTRL_TOPBIT_EN = 2;
  localparam int unsigned CTRL_EXT_INCR = 3;
  // reset values
  localparam logic [11:0] CTRL_RST = 12'h000;
  localparam logic [11:0] NINCR_RST = 12'h000;
  localparam logic [11:0] TINT_RST = 12'h001;
  localparam logic [11:0] ZERO12 = 12'h000;

  // software-visible configuration
  typedef struct packed {
    logic [11:0] ctrl;
    logic [23:0] fstart;
    logic [23:0] delta;
    logic [11:0] nincr;
    logic [11:0] tint;
  } swg_cfg_t;

  // sweep sequencer states, one-hot
  typedef enum logic [2:0] {
    SWG_IDLE = 3'b001,
    SWG_RUN = 3'b010,
    SWG_HOLD = 3'b100
  } swg_state_t;
endpackage : swg_pkg

// File: swg_top.sv
// Implementation choices: the Wishbone register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module swg_top (
  input wire logic clk, // 20 MHz master clock
  input wire logic sys_rst, // async reset, active high
  input wire logic sclk, // serial clock from host
  input wire logic frame_select_n, // serial frame, active low
  input wire logic serial_word_in, // serial data
  input wire logic trigger_in, // sweep start / step pin
  input wire logic interrupt_in, // sweep abort pin
  input wire logic standby_in, // clock freeze pin
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte enables
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  output logic [9:0] dac_code, // code to the dac
  output logic sweep_status_out, // status pin
  output logic inverted_top_bit_out // inverted dac msb pin
);

  ////////////////////////////////////////////////////////////////////////
  // merge 12 data bits into a register under a bit mask
  function automatic swg_pkg::swg_cfg_t apply_write(
    input swg_pkg::swg_cfg_t c, input logic [3:0] idx,
    input logic [11:0] d, input logic [11:0] m);
    swg_pkg::swg_cfg_t r;
    r = c;
    case (idx)
      swg_pkg::IDX_CTRL: r.ctrl = (c.ctrl & ~m) | (d & m);
      swg_pkg::IDX_FSTART_LO: r.fstart[11:0] = (c.fstart[11:0] & ~m) | (d & m);
      swg_pkg::IDX_FSTART_HI: r.fstart[23:12] = (c.fstart[23:12] & ~m) | (d & m);
      swg_pkg::IDX_DELTA_LO: r.delta[11:0] = (c.delta[11:0] & ~m) | (d & m);
      swg_pkg::IDX_DELTA_HI: r.delta[23:12] = (c.delta[23:12] & ~m) | (d & m);
      swg_pkg::IDX_NINCR: r.nincr = (c.nincr & ~m) | (d & m);
      swg_pkg::IDX_TINT: r.tint = (c.tint & ~m) | (d & m);
      default: r = c;
    endcase
    return r;
  endfunction : apply_write

  ////////////////////////////////////////////////////////////////////////
  // serial link domain, clocked by the host's serial clock
  logic [3:0] bit_cnt_r, bit_cnt_nxt;
  logic [14:0] shift_r, shift_nxt;
  logic [15:0] word_r, word_nxt;
  logic word_tgl_r, word_tgl_nxt;

  // shift on each bit, hand a full word over with a toggle
  always_comb begin
    bit_cnt_nxt = bit_cnt_r + 4'h1; // wraps so held frames keep going
    shift_nxt = {shift_r[13:0], serial_word_in}; // first bit ends up on top
    word_nxt = word_r;
    word_tgl_nxt = word_tgl_r;
    if (bit_cnt_r == swg_pkg::LAST_BIT) begin
      word_nxt = {shift_r, serial_word_in}; // address nibble then data
      word_tgl_nxt = ~word_tgl_r;
    end
  end

  // frame high clears the bit count; clock stands still between frames
  always_ff @(negedge sclk or posedge frame_select_n or posedge sys_rst) begin
    if (sys_rst) begin
      bit_cnt_r <= 4'h0;
      shift_r <= 15'h0000;
      word_r <= 16'h0000;
      word_tgl_r <= 1'b0;
    end else if (frame_select_n) begin
      bit_cnt_r <= 4'h0; // next low frame starts a fresh word
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      shift_r <= shift_nxt;
      word_r <= word_nxt;
      word_tgl_r <= word_tgl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // synchronisers into the master clock domain
  logic [2:0] tgl_sync_r; // two stages plus previous value
  logic [2:0] trig_sync_r, irq_sync_r;
  logic [1:0] stby_sync_r;
  logic [15:0] word_hold_r;
  logic word_new;
  logic trig_rise, irq_rise, standby_s;

  // stage 0 feeds only stage 1; edges look at stages 1 and 2
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tgl_sync_r <= 3'h0;
      trig_sync_r <= 3'h0;
      irq_sync_r <= 3'h0;
      stby_sync_r <= 2'h0;
      word_hold_r <= 16'h0000;
    end else begin
      tgl_sync_r <= {tgl_sync_r[1:0], word_tgl_r};
      trig_sync_r <= {trig_sync_r[1:0], trigger_in};
      irq_sync_r <= {irq_sync_r[1:0], interrupt_in};
      stby_sync_r <= {stby_sync_r[0], standby_in};
      // word is stable for 16 serial clocks after its toggle, so sample late
      word_hold_r <= word_r;
    end
  end

  assign word_new = tgl_sync_r[2] ^ tgl_sync_r[1];
  assign trig_rise = trig_sync_r[1] & ~trig_sync_r[2];
  assign irq_rise = irq_sync_r[1] & ~irq_sync_r[2];
  assign standby_s = stby_sync_r[1];

  ////////////////////////////////////////////////////////////////////////
  // configuration registers and wishbone slave
  swg_pkg::swg_cfg_t cfg_r, cfg_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdat_r, rdat_nxt;
  logic [3:0] wb_idx;
  logic wb_hit;
  logic [11:0] wb_mask;
  logic [11:0] status_word;
  swg_pkg::swg_state_t state_r, state_nxt;
  logic [11:0] step_r, step_nxt;

  assign wb_idx = wb_adr_i[5:2];
  assign wb_hit = (wb_adr_i[7:6] == 2'h0);
  assign wb_mask = {{4{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign status_word = {state_r == swg_pkg::SWG_IDLE ? 1'b0 : 1'b1, 11'h000} | {1'b0, step_r[10:0]};

  // serial word wins a same-cycle clash; software retries nothing, the bus write is lost
  always_comb begin
    cfg_nxt = cfg_r;
    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    rdat_nxt = 32'h0000_0000;
    if (word_new) begin
      cfg_nxt = apply_write(cfg_r, word_hold_r[15:12], word_hold_r[11:0], 12'hfff);
    end else if (ack_nxt && wb_we_i && wb_hit) begin
      cfg_nxt = apply_write(cfg_r, wb_idx, wb_dat_i[11:0], wb_mask);
    end
    if (ack_nxt && !wb_we_i && wb_hit) begin
      case (wb_idx)
        swg_pkg::IDX_CTRL: rdat_nxt[11:0] = cfg_r.ctrl;
        swg_pkg::IDX_FSTART_LO: rdat_nxt[11:0] = cfg_r.fstart[11:0];
        swg_pkg::IDX_FSTART_HI: rdat_nxt[11:0] = cfg_r.fstart[23:12];
        swg_pkg::IDX_DELTA_LO: rdat_nxt[11:0] = cfg_r.delta[11:0];
        swg_pkg::IDX_DELTA_HI: rdat_nxt[11:0] = cfg_r.delta[23:12];
        swg_pkg::IDX_NINCR: rdat_nxt[11:0] = cfg_r.nincr;
        swg_pkg::IDX_TINT: rdat_nxt[11:0] = cfg_r.tint;
        swg_pkg::IDX_STATUS: rdat_nxt[11:0] = status_word;
        default: rdat_nxt = 32'h0000_0000;
      endcase
    end
  end

  // register file and bus answer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg_r.ctrl <= swg_pkg::CTRL_RST;
      cfg_r.fstart <= 24'h000000;
      cfg_r.delta <= 24'h000000;
      cfg_r.nincr <= swg_pkg::NINCR_RST;
      cfg_r.tint <= swg_pkg::TINT_RST;
      ack_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end else begin
      cfg_r <= cfg_nxt;
      ack_r <= ack_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  ////////////////////////////////////////////////////////////////////////
  // sweep sequencer and phase accumulator
  logic [23:0] freq_r, freq_nxt;
  logic [23:0] phase_r, phase_nxt;
  logic [11:0] tcnt_r, tcnt_nxt;
  logic [9:0] dac_r, dac_nxt;
  logic stat_r, stat_nxt;
  logic top_r, top_nxt;
  logic ext_mode, do_step, last_step, end_of_sweep, incr;

  assign ext_mode = cfg_r.ctrl[swg_pkg::CTRL_EXT_INCR];
  assign last_step = (step_r == cfg_r.nincr);

  always_comb begin
    state_nxt = state_r;
    freq_nxt = freq_r;
    phase_nxt = phase_r;
    step_nxt = step_r;
    tcnt_nxt = tcnt_r;
    dac_nxt = dac_r;
    stat_nxt = stat_r;
    top_nxt = top_r;
    do_step = 1'b0;
    end_of_sweep = 1'b0;
    incr = 1'b0;
    if (!standby_s) begin // frozen while standby is high
      case (state_r)
        swg_pkg::SWG_IDLE: begin
          if (trig_rise && !irq_rise) begin
            state_nxt = ext_mode ? swg_pkg::SWG_HOLD : swg_pkg::SWG_RUN;
          end
        end
        swg_pkg::SWG_RUN: begin
          if (tcnt_r + 12'h001 >= cfg_r.tint) begin
            do_step = 1'b1; // self-timed steps, no further trigger
          end
        end
        swg_pkg::SWG_HOLD: begin
          do_step = trig_rise; // one step per trigger pulse
        end
        default: state_nxt = swg_pkg::SWG_IDLE;
      endcase
      // start or restart: load the profile from the beginning
      // in hold a trigger only steps while external mode is still selected;
      // otherwise a mode change to auto would leave the sweep parked forever
      if (trig_rise && (state_r != swg_pkg::SWG_HOLD || !ext_mode)) begin
        if (state_r != swg_pkg::SWG_IDLE) begin
          state_nxt = ext_mode ? swg_pkg::SWG_HOLD : swg_pkg::SWG_RUN;
        end
        do_step = 1'b0;
        freq_nxt = cfg_r.fstart;
        phase_nxt = 24'h000000;
        step_nxt = 12'h000;
        tcnt_nxt = 12'h000;
      end else begin
        tcnt_nxt = do_step ? 12'h000 : tcnt_r + 12'h001;
        phase_nxt = phase_r + freq_r; // fout = clk * freq / 2^24
        if (do_step) begin
          incr = 1'b1;
          if (last_step) begin
            end_of_sweep = 1'b1; // saw sweep wraps back to the start frequency
            step_nxt = 12'h000;
            freq_nxt = cfg_r.fstart;
          end else begin
            step_nxt = step_r + 12'h001;
            freq_nxt = freq_r + cfg_r.delta;
          end
        end
      end
      // abort wins over any trigger in the same cycle
      if (irq_rise) begin
        state_nxt = swg_pkg::SWG_IDLE;
        phase_nxt = 24'h000000;
        step_nxt = 12'h000;
        tcnt_nxt = 12'h000;
        end_of_sweep = 1'b0;
        incr = 1'b0;
      end
      dac_nxt = (state_nxt == swg_pkg::SWG_IDLE) ? swg_pkg::DAC_MID : phase_nxt[23:14];
      stat_nxt = cfg_r.ctrl[swg_pkg::CTRL_STATUS_EN] &
        (cfg_r.ctrl[swg_pkg::CTRL_STATUS_SRC] ? incr : end_of_sweep);
      top_nxt = cfg_r.ctrl[swg_pkg::CTRL_TOPBIT_EN] & ~dac_nxt[9];
    end
  end

  // sequencer registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= swg_pkg::SWG_IDLE;
      freq_r <= 24'h000000;
      phase_r <= 24'h000000;
      step_r <= 12'h000;
      tcnt_r <= 12'h000;
      dac_r <= swg_pkg::DAC_MID;
      stat_r <= 1'b0;
      top_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      freq_r <= freq_nxt;
      phase_r <= phase_nxt;
      step_r <= step_nxt;
      tcnt_r <= tcnt_nxt;
      dac_r <= dac_nxt;
      stat_r <= stat_nxt;
      top_r <= top_nxt;
    end
  end

  assign dac_code = dac_r;
  assign sweep_status_out = stat_r;
  assign inverted_top_bit_out = top_r;
endmodule : swg_top
`default_nettype wire

// File: swg_top_properties.sv
`timescale 1ns/100ps
`default_nettype none
module swg_top_properties (
  input wire logic clk, // master clock
  input wire logic sys_rst, // async reset
  input wire logic interrupt_in, // abort pin
  input wire logic standby_in, // freeze pin
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // bus strobe
  input wire logic [31:0] wb_dat_o, // read data
  input wire logic wb_ack_o, // acknowledge
  input wire logic [9:0] dac_code, // dac code
  input wire logic sweep_status_out, // status pin
  input wire logic inverted_top_bit_out // top bit pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////
  // bus answers once, one cycle after the request
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not cleared");
  // pins come out of reset quiet and at midscale
  rst_vals_a: assert property ($fell(sys_rst) |-> dac_code == swg_pkg::DAC_MID
    && !sweep_status_out && !inverted_top_bit_out) else $error("bad reset state");
  // compared only on a settled code; the pin is registered on the same edge as the code
  top_bit_a: assert property ($stable(dac_code) && inverted_top_bit_out |-> !dac_code[9])
    else $error("top bit not inverted");
  irq_mid_a: assert property ($rose(interrupt_in) && !standby_in |-> ##[1:5]
    dac_code == swg_pkg::DAC_MID) else $error("no midscale after abort");
  // sync takes two edges, so the fifth high sample must be frozen
  freeze_a: assert property (standby_in [*5] |-> $stable(dac_code))
    else $error("dac moved in standby");
  cover property (sweep_status_out);
  cover property (standby_in [*5]);
  cover property ($rose(interrupt_in));
endmodule : swg_top_properties
bind swg_top swg_top_properties chk_u (.clk(clk), .sys_rst(sys_rst), .interrupt_in(interrupt_in),
  .standby_in(standby_in), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .dac_code(dac_code), .sweep_status_out(sweep_status_out),
  .inverted_top_bit_out(inverted_top_bit_out));
`default_nettype wire

// File: swg_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module swg_host_model (
  output logic sclk, // serial clock, idles high
  output logic frame_select_n, // frame, active low
  output logic serial_word_in // serial data
);
  initial begin
    sclk = 1'b1;
    frame_select_n = 1'b1;
    serial_word_in = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // sends the top nb bits; clock stands still outside frames
  task automatic send_word(input logic [15:0] w, input int nb, input logic keep);
    #7 frame_select_n = 1'b0;
    for (int i = 15; i > 15 - nb; i--) begin
      serial_word_in = w[i];
      #62.5 sclk = 1'b0;
      #62.5 sclk = 1'b1;
    end
    if (!keep) begin
      #62.5 frame_select_n = 1'b1;
      serial_word_in = ~serial_word_in; // released line shows no stale bit
    end
  endtask : send_word
endmodule : swg_host_model
`default_nettype wire

// File: swg_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module swg_top_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic trigger_in = 1'b0;
  logic interrupt_in = 1'b0;
  logic standby_in = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, sweep_status_out, inverted_top_bit_out;
  logic [9:0] dac_code, d0;
  wire sclk, frame_select_n, serial_word_in;
  int err_total = 0;
  int compares = 0;
  int pulses;
  logic [11:0] ctl [3] = '{12'h006, 12'h007, 12'h004};
  int expn [3] = '{10, 30, 0};
  always #25 clk = ~clk;
  swg_host_model host_u (.sclk(sclk), .frame_select_n(frame_select_n), .serial_word_in(serial_word_in));
  swg_top dut_u (.clk(clk), .sys_rst(sys_rst), .sclk(sclk), .frame_select_n(frame_select_n),
    .serial_word_in(serial_word_in), .trigger_in(trigger_in), .interrupt_in(interrupt_in),
    .standby_in(standby_in), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .dac_code(dac_code), .sweep_status_out(sweep_status_out),
    .inverted_top_bit_out(inverted_top_bit_out));
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one classic cycle, held until ack is sampled
  task automatic wb(input logic we, input logic [3:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {2'b00, idx, 2'b00};
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      err_total++;
      give_verdict();
    end
  endtask : wb
  task automatic rdchk(input string nm, input logic [3:0] idx, input logic [31:0] exp);
    wb(1'b0, idx, 32'h0);
    chk(nm, exp, rd);
  endtask : rdchk
  // pulses held three cycles, wider than the two-flop sync needs
  task automatic pins(input logic irq, input logic trg);
    @(posedge clk);
    interrupt_in <= irq;
    trigger_in <= trg;
    repeat (3) @(posedge clk);
    interrupt_in <= 1'b0;
    trigger_in <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : pins
  initial begin
    #2000000;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    chk("dac reset", 32'h200, {22'h0, dac_code});
    rdchk("tint reset", 4'h6, 32'h1);
    wb(1'b1, 4'h7, 32'h5a5);
    rdchk("unmapped", 4'h7, 32'h0);
    $display("test reset done");
    host_u.send_word(16'h5abc, 16, 1'b0);
    repeat (8) @(posedge clk);
    rdchk("nincr", 4'h5, 32'habc);
    host_u.send_word(16'h3123, 16, 1'b1);
    host_u.send_word(16'h4456, 16, 1'b0);
    host_u.send_word(16'h6777, 8, 1'b0); // partial word must be dropped
    repeat (8) @(posedge clk);
    rdchk("delta lo", 4'h3, 32'h123);
    rdchk("delta hi", 4'h4, 32'h456);
    rdchk("partial", 4'h6, 32'h1);
    $display("test serial done");
    wb(1'b1, 4'h1, 32'h0);
    wb(1'b1, 4'h2, 32'h0);
    wb(1'b1, 4'h3, 32'h0);
    wb(1'b1, 4'h4, 32'h4);
    wb(1'b1, 4'h5, 32'h2);
    wb(1'b1, 4'h6, 32'h4);
    wb(1'b1, 4'h0, 32'h8);
    pins(1'b0, 1'b1);
    chk("dac start", 32'h0, {22'h0, dac_code});
    chk("top off", 32'h0, {31'h0, inverted_top_bit_out});
    rdchk("step0", 4'h8, 32'h800);
    wb(1'b1, 4'h0, 32'hc);
    repeat (3) @(posedge clk);
    chk("top on", 32'h1, {31'h0, inverted_top_bit_out});
    pins(1'b0, 1'b1);
    rdchk("step1", 4'h8, 32'h801);
    d0 = dac_code;
    @(posedge clk);
    chk("ramp", 32'h1, {22'h0, dac_code - d0});
    pins(1'b0, 1'b1);
    rdchk("step2", 4'h8, 32'h802);
    $display("test external done");
    wb(1'b1, 4'h5, 32'h2);
    wb(1'b1, 4'h0, 32'h6);
    pins(1'b0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, 4'h0, {20'h0, ctl[i]});
      repeat (4) @(posedge clk);
      pulses = 0;
      repeat (120) begin
        @(posedge clk);
        pulses += (sweep_status_out === 1'b1);
      end
      chk("status pulses", expn[i], pulses);
    end
    $display("test auto done");
    standby_in <= 1'b1;
    repeat (4) @(posedge clk);
    d0 = dac_code;
    repeat (10) @(posedge clk);
    chk("standby", {22'h0, d0}, {22'h0, dac_code});
    standby_in <= 1'b0;
    pins(1'b1, 1'b0);
    chk("abort dac", 32'h200, {22'h0, dac_code});
    rdchk("abort busy", 4'h8, 32'h0);
    pins(1'b1, 1'b1);
    chk("tie dac", 32'h200, {22'h0, dac_code});
    $display("test abort done");
    sys_rst <= 1'b1; // host resets before standby
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    standby_in <= 1'b1;
    repeat (4) @(posedge clk);
    pins(1'b0, 1'b1);
    chk("standby trigger", 32'h200, {22'h0, dac_code});
    standby_in <= 1'b0;
    repeat (4) @(posedge clk);
    chk("after standby", 32'h200, {22'h0, dac_code});
    $display("test standby done");
    give_verdict();
  end
endmodule : swg_top_tb
`default_nettype wire
